// *** hdl/cpuc_core_regs.v ***
// architectural register set of the 8-bit core; literal ops, calls, interrupts and pops take two cycles, returns three.
// assumes a decoder issues one instruction per valid/ready handshake and
// that pins, capture input are asynchronous; irq requests are on clk_in.
// Operation
// [RULE1] 16-bit fetch address resets to zero
// [RULE2] fetch address advances by instruction length
// [RULE3] fetch address changed only by branches
// [RULE4] opcode held internally, not software visible
// [RULE5] four banks of eight working bytes
// [RULE6] bank chosen by flags bank-select bits
// [RULE7] register k of bank n at 8n+k
// [RULE8] register ops one cycle, literal two
// [RULE9] parity flag follows accumulator continuously
// [RULE10] ones count plus parity always even
// [RULE11] auxiliary register feeds multiply and divide
// [RULE12] flags hold carry, aux carry, overflow
// [RULE13] pointer usable as word or bytes
// [RULE14] two selectable memory pointers
// [RULE15] push increments pointer then writes
// [RULE16] pop reads then decrements pointer
// [RULE17] calls and interrupts stack return address
// [RULE18] stack lives in extended internal ram
// [RULE19] software sets stack origin by writing
// [RULE20] three timers, third captures on input
// [RULE21] two priority levels plus supply tier
// [RULE22] twenty port pins, no external memory
// [RULE23] per-pin pull-ups on ports one, two
// [RULE24] idle and power-down, control not bit-addressable
// [RULE25] stack pointer wraps modulo 256
`timescale 1ns/1ns
`include "cpuc_defs.vh"

module cpuc_core_regs #(
  parameter NUM_IRQ = 4
) (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // instruction issue
  input wire instr_valid_in,
  input wire [3:0] instr_kind_in,
  input wire [7:0] instr_opcode_in,
  input wire [1:0] instr_len_in,
  input wire [1:0] instr_alu_op_in,
  input wire [2:0] instr_reg_idx_in,
  input wire [7:0] instr_operand_in,
  input wire [15:0] instr_target_in,
  output wire instr_ready_out,
  // core state
  output wire [15:0] fetch_address_out,
  output wire [7:0] current_opcode_out,
  output wire [7:0] acc_out,
  output wire [15:0] mem_pointer_pair_out,
  output wire [7:0] stack_top_pointer_out,
  output wire [7:0] sfr_rdata_out,
  output wire sfr_rvalid_out,
  // port pins, open drain with switchable pull-ups
  input wire [19:0] pin_in,
  output wire [19:0] pin_out,
  output wire [19:0] pin_oe_out,
  output wire [19:0] pullup_en_out,
  // timer capture and interrupts
  input wire capture_pin_in,
  input wire [NUM_IRQ-1:0] irq_req_in,
  input wire supply_monitor_irq_in,
  output wire [1:0] irq_tier_out,
  output wire [2:0] irq_src_out,
  // power modes
  output wire idle_mode_out,
  output wire power_down_out
);

  localparam S_IDLE = 6'h01;
  localparam S_TWO = 6'h02;
  localparam S_CALL_HI = 6'h04;
  localparam S_POP = 6'h08;
  localparam S_RET_HI = 6'h10;
  localparam S_RET_LO = 6'h20;

  reg [5:0] state_q, state_d;
  reg [15:0] pc_q;
  reg [7:0] opc_q;
  reg [7:0] acc_q, b_q, pctl_q, sp_q, cfg_q, pu1_q, rdata_q, pop_addr_q, ret_hi_q;
  reg [7:1] flg_q;
  reg [15:0] dp0_q, dp1_q;
  reg dpsel_q, rvalid_q;
  reg [19:0] port_q, pin_s1_q, pin_s2_q;
  reg [3:0] pu2_q, tctl_q;
  reg [7:0] iprio_q;
  reg [1:0] xpwr_q, tier_q;
  reg [2:0] src_q;
  reg cap_s1_q, cap_s2_q, cap_s3_q;
  reg wb_q, wb_lit_q;
  reg [3:0] wb_kind_q;
  reg [1:0] wb_op_q;
  reg [7:0] wb_opnd_q;

  wire take;
  wire alu_kind;
  wire [1:0] rs;
  wire [7:0] flg_rd;
  wire [15:0] cur_dp;
  wire [7:0] bank_rdata, xram_rdata;
  wire [15:0] t0_cnt, t1_cnt, t2_cnt, t2_cap;
  wire [15:0] pc_next;
  wire [15:0] ret_pc;

  ////////////////////////////////////////////////////////////////////////////
  // issue handshake

  assign alu_kind = (instr_kind_in == `CPUC_K_ACC_REG) || (instr_kind_in == `CPUC_K_ACC_LIT) ||
                    (instr_kind_in == `CPUC_K_MUL) || (instr_kind_in == `CPUC_K_DIV);
  // non-alu kinds wait one cycle behind an alu result so they see it
  assign instr_ready_out = state_q[0] & ~(wb_q & ~alu_kind);
  assign take = instr_valid_in & instr_ready_out;
  assign rs = flg_q[`CPUC_FLG_RS_HI:`CPUC_FLG_RS_LO]; // RULE6
  assign flg_rd = {flg_q, ^acc_q}; // RULE9 RULE10
  assign cur_dp = dpsel_q ? dp1_q : dp0_q; // RULE14
  assign pc_next = pc_q + {14'h0000, instr_len_in}; // RULE2
  assign ret_pc = (instr_kind_in == `CPUC_K_IRQ) ? pc_q : pc_next;

  ////////////////////////////////////////////////////////////////////////////
  // special-register read mux (fetch address and opcode are not in it)

  reg [7:0] sfr_mux;
  always @* begin
    case (instr_operand_in) // RULE3 RULE4
      `CPUC_SFR_ACC: sfr_mux = acc_q;
      `CPUC_SFR_B: sfr_mux = b_q;
      `CPUC_SFR_FLG: sfr_mux = flg_rd;
      `CPUC_SFR_PCTL: sfr_mux = pctl_q;
      `CPUC_SFR_MPL: sfr_mux = cur_dp[7:0]; // RULE13
      `CPUC_SFR_MPH: sfr_mux = cur_dp[15:8]; // RULE13
      `CPUC_SFR_DPSEL: sfr_mux = {7'h00, dpsel_q};
      `CPUC_SFR_SP: sfr_mux = sp_q;
      `CPUC_SFR_CFG: sfr_mux = cfg_q;
      `CPUC_SFR_PT0: sfr_mux = pin_s2_q[7:0];
      `CPUC_SFR_PT1: sfr_mux = pin_s2_q[15:8];
      `CPUC_SFR_PT2: sfr_mux = {4'h0, pin_s2_q[19:16]};
      `CPUC_SFR_PU1: sfr_mux = pu1_q;
      `CPUC_SFR_PU2: sfr_mux = {4'h0, pu2_q};
      `CPUC_SFR_IPRIO: sfr_mux = iprio_q;
      `CPUC_SFR_XPWR: sfr_mux = {6'h00, xpwr_q};
      `CPUC_SFR_TCTL: sfr_mux = {4'h0, tctl_q};
      `CPUC_SFR_T0L: sfr_mux = t0_cnt[7:0];
      `CPUC_SFR_T0H: sfr_mux = t0_cnt[15:8];
      `CPUC_SFR_T1L: sfr_mux = t1_cnt[7:0];
      `CPUC_SFR_T1H: sfr_mux = t1_cnt[15:8];
      `CPUC_SFR_T2L: sfr_mux = t2_cnt[7:0];
      `CPUC_SFR_T2H: sfr_mux = t2_cnt[15:8];
      `CPUC_SFR_CAPL: sfr_mux = t2_cap[7:0];
      `CPUC_SFR_CAPH: sfr_mux = t2_cap[15:8];
      default: sfr_mux = `CPUC_RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // special-register write path: byte write, bit write, pop completion

  reg sfr_we;
  reg [7:0] sfr_wa, sfr_wd, bit_base;
  always @* begin
    sfr_we = 1'b0;
    sfr_wa = instr_operand_in;
    sfr_wd = instr_target_in[7:0];
    // bit writes to ports modify the latch, not the pin level
    case (instr_operand_in)
      `CPUC_SFR_PT0: bit_base = port_q[7:0];
      `CPUC_SFR_PT1: bit_base = port_q[15:8];
      `CPUC_SFR_PT2: bit_base = {4'h0, port_q[19:16]};
      default: bit_base = sfr_mux;
    endcase
    if (state_q == S_POP) begin
      sfr_we = 1'b1; // RULE16
      sfr_wa = pop_addr_q;
      sfr_wd = xram_rdata;
    end else if (take && instr_kind_in == `CPUC_K_SFR_WR) begin
      sfr_we = 1'b1;
    end else if (take && instr_kind_in == `CPUC_K_SFR_BIT &&
                 (instr_operand_in & `CPUC_BITADDR_MASK) == 8'h00) begin
      // only addresses on an eight-byte boundary take bit writes
      sfr_we = 1'b1; // RULE12 RULE22 RULE24
      sfr_wd = bit_base;
      sfr_wd[instr_reg_idx_in] = instr_target_in[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alu, multiply and divide in the stage after issue

  reg [7:0] opnd, sum8, acc_d, b_d;
  reg [8:0] sum9;
  reg [4:0] lo5;
  reg [15:0] prod;
  reg sub, cin, cy_d, ac_d, ov_d;
  always @* begin
    opnd = wb_lit_q ? wb_opnd_q : bank_rdata; // RULE8
    sub = (wb_op_q == `CPUC_OP_SUBB);
    cin = (wb_op_q == `CPUC_OP_ADD) ? 1'b0 : flg_q[`CPUC_FLG_CY];
    sum8 = sub ? ~opnd : opnd;
    sum9 = {1'b0, acc_q} + {1'b0, sum8} + {8'h00, cin ^ sub};
    lo5 = {1'b0, acc_q[3:0]} + {1'b0, sum8[3:0]} + {4'h0, cin ^ sub};
    prod = acc_q * b_q;
    acc_d = acc_q;
    b_d = b_q;
    cy_d = flg_q[`CPUC_FLG_CY];
    ac_d = flg_q[`CPUC_FLG_AC];
    ov_d = flg_q[`CPUC_FLG_OV];
    case (wb_kind_q)
      `CPUC_K_MUL: begin
        acc_d = prod[7:0]; // RULE11
        b_d = prod[15:8];
        cy_d = 1'b0;
        ov_d = (prod[15:8] != 8'h00);
      end
      `CPUC_K_DIV: begin
        cy_d = 1'b0;
        ov_d = (b_q == 8'h00); // RULE11
        if (b_q != 8'h00) begin
          acc_d = acc_q / b_q;
          b_d = acc_q % b_q;
        end
      end
      default: begin
        if (wb_op_q == `CPUC_OP_MOV) begin
          acc_d = opnd;
        end else begin
          acc_d = sum9[7:0]; // RULE12
          cy_d = sum9[8] ^ sub;
          ac_d = lo5[4] ^ sub;
          ov_d = (acc_q[7] == sum8[7]) && (sum9[7] != acc_q[7]);
        end
      end
    endcase
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_q <= `CPUC_RST_BYTE;
      b_q <= `CPUC_RST_BYTE;
      flg_q <= 7'h00;
    end else begin
      // a later special-register write overrides an earlier alu result
      if (sfr_we && sfr_wa == `CPUC_SFR_ACC) begin
        acc_q <= sfr_wd;
      end else if (wb_q) begin
        acc_q <= acc_d;
      end
      if (sfr_we && sfr_wa == `CPUC_SFR_B) begin
        b_q <= sfr_wd;
      end else if (wb_q) begin
        b_q <= b_d;
      end
      if (sfr_we && sfr_wa == `CPUC_SFR_FLG) begin
        flg_q <= sfr_wd[7:1];
      end else if (wb_q) begin
        flg_q[`CPUC_FLG_CY] <= cy_d; // RULE12
        flg_q[`CPUC_FLG_AC] <= ac_d;
        flg_q[`CPUC_FLG_OV] <= ov_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer, fetch address and stack

  always @* begin
    case (state_q)
      S_IDLE: begin
        state_d = S_IDLE;
        if (take) begin
          case (instr_kind_in)
            `CPUC_K_ACC_LIT: state_d = S_TWO; // RULE8
            `CPUC_K_CALL, `CPUC_K_IRQ: state_d = S_CALL_HI;
            `CPUC_K_POP: state_d = S_POP;
            `CPUC_K_RET: state_d = S_RET_HI;
            default: state_d = S_IDLE;
          endcase
        end
      end
      S_RET_HI: state_d = S_RET_LO;
      S_TWO, S_CALL_HI, S_POP, S_RET_LO: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  reg xram_we;
  reg [7:0] xram_wd;
  wire [7:0] sp_inc = sp_q + 8'h01; // RULE25
  wire [7:0] sp_dec = sp_q - 8'h01; // RULE25
  wire [7:0] xram_raddr = (state_q == S_RET_HI) ? sp_dec : sp_q;
  always @* begin
    xram_we = 1'b0;
    xram_wd = ret_pc[7:0];
    if (state_q == S_CALL_HI) begin
      xram_we = 1'b1; // RULE17
      xram_wd = ret_hi_q;
    end else if (take && instr_kind_in == `CPUC_K_PUSH) begin
      xram_we = 1'b1; // RULE15
      xram_wd = sfr_mux;
    end else if (take && (instr_kind_in == `CPUC_K_CALL || instr_kind_in == `CPUC_K_IRQ)) begin
      xram_we = 1'b1; // RULE17
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= S_IDLE;
      pc_q <= `CPUC_RST_PC; // RULE1
      opc_q <= `CPUC_RST_BYTE;
      sp_q <= `CPUC_RST_SP;
      ret_hi_q <= `CPUC_RST_BYTE;
      pop_addr_q <= `CPUC_RST_BYTE;
      wb_q <= 1'b0;
      wb_lit_q <= 1'b0;
      wb_kind_q <= `CPUC_K_NEXT;
      wb_op_q <= `CPUC_OP_ADD;
      wb_opnd_q <= `CPUC_RST_BYTE;
      rdata_q <= `CPUC_RST_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wb_q <= take && alu_kind;
      rvalid_q <= take && instr_kind_in == `CPUC_K_SFR_RD;
      if (take) begin
        opc_q <= instr_opcode_in; // RULE4
        wb_kind_q <= instr_kind_in;
        wb_op_q <= instr_alu_op_in;
        wb_lit_q <= (instr_kind_in == `CPUC_K_ACC_LIT);
        wb_opnd_q <= instr_operand_in;
        pop_addr_q <= instr_operand_in;
        rdata_q <= sfr_mux;
        ret_hi_q <= ret_pc[15:8];
        case (instr_kind_in)
          `CPUC_K_JUMP, `CPUC_K_CALL, `CPUC_K_IRQ: pc_q <= instr_target_in; // RULE3 RULE17
          `CPUC_K_RET: pc_q <= pc_q;
          default: pc_q <= pc_next; // RULE2
        endcase
      end
      if (state_q == S_RET_HI) begin
        ret_hi_q <= xram_rdata;
      end
      if (state_q == S_RET_LO) begin
        pc_q <= {ret_hi_q, xram_rdata}; // RULE17
      end
      if (sfr_we && sfr_wa == `CPUC_SFR_SP) begin
        sp_q <= sfr_wd; // RULE19
      end else if (xram_we) begin
        sp_q <= sp_inc; // RULE15
      end else if (state_q == S_POP || state_q == S_RET_HI || state_q == S_RET_LO) begin
        sp_q <= sp_dec; // RULE16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // remaining special registers

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pctl_q <= `CPUC_RST_BYTE;
      cfg_q <= `CPUC_RST_CFG;
      dp0_q <= {`CPUC_RST_BYTE, `CPUC_RST_BYTE};
      dp1_q <= {`CPUC_RST_BYTE, `CPUC_RST_BYTE};
      dpsel_q <= 1'b0;
      port_q <= `CPUC_RST_PORT;
      pu1_q <= `CPUC_RST_PU1;
      pu2_q <= `CPUC_RST_PU2;
      iprio_q <= `CPUC_RST_BYTE;
      xpwr_q <= 2'h0;
      tctl_q <= 4'h0;
    end else begin
      if (take && instr_kind_in == `CPUC_K_MPTR_LD) begin
        if (dpsel_q) begin
          dp1_q <= instr_target_in; // RULE13 RULE14
        end else begin
          dp0_q <= instr_target_in;
        end
      end
      if (sfr_we) begin
        case (sfr_wa)
          `CPUC_SFR_PCTL: pctl_q <= sfr_wd;
          `CPUC_SFR_CFG: cfg_q <= sfr_wd;
          `CPUC_SFR_DPSEL: dpsel_q <= sfr_wd[0]; // RULE14
          `CPUC_SFR_MPL: begin
            if (dpsel_q) dp1_q[7:0] <= sfr_wd; else dp0_q[7:0] <= sfr_wd; // RULE13
          end
          `CPUC_SFR_MPH: begin
            if (dpsel_q) dp1_q[15:8] <= sfr_wd; else dp0_q[15:8] <= sfr_wd; // RULE13
          end
          `CPUC_SFR_PT0: port_q[7:0] <= sfr_wd;
          `CPUC_SFR_PT1: port_q[15:8] <= sfr_wd;
          `CPUC_SFR_PT2: port_q[19:16] <= sfr_wd[3:0];
          `CPUC_SFR_PU1: pu1_q <= sfr_wd; // RULE23
          `CPUC_SFR_PU2: pu2_q <= sfr_wd[3:0]; // RULE23
          `CPUC_SFR_IPRIO: iprio_q <= sfr_wd; // RULE21
          `CPUC_SFR_XPWR: xpwr_q <= sfr_wd[1:0]; // RULE24
          `CPUC_SFR_TCTL: tctl_q <= sfr_wd[3:0];
          default: pctl_q <= pctl_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins, capture input, interrupt tiers

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_s1_q <= `CPUC_RST_PORT;
      pin_s2_q <= `CPUC_RST_PORT;
      cap_s1_q <= 1'b0;
      cap_s2_q <= 1'b0;
      cap_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      cap_s1_q <= capture_pin_in;
      cap_s2_q <= cap_s1_q;
      cap_s3_q <= cap_s2_q;
    end
  end

  // port 0 never has a pull-up; a zero latch bit drives the pin low
  assign pin_out = 20'h00000; // RULE22
  assign pin_oe_out = ~port_q;
  assign pullup_en_out = {pu2_q, pu1_q, 8'h00}; // RULE23

  reg hi_any, lo_any;
  reg [2:0] hi_src, lo_src;
  integer i;
  always @* begin
    hi_any = 1'b0;
    lo_any = 1'b0;
    hi_src = 3'h0;
    lo_src = 3'h0;
    // downward scan leaves the lowest-numbered request as the winner
    for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
      if (irq_req_in[i] && iprio_q[i]) begin
        hi_any = 1'b1;
        hi_src = i[2:0];
      end
      if (irq_req_in[i]) begin
        lo_any = 1'b1;
        lo_src = i[2:0];
      end
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tier_q <= `CPUC_TIER_NONE;
      src_q <= 3'h0;
    end else if (supply_monitor_irq_in) begin
      tier_q <= `CPUC_TIER_SUPPLY; // RULE21
      src_q <= `CPUC_SRC_SUPPLY;
    end else if (hi_any) begin
      tier_q <= `CPUC_TIER_HIGH; // RULE21
      src_q <= hi_src;
    end else if (lo_any) begin
      tier_q <= `CPUC_TIER_LOW;
      src_q <= lo_src;
    end else begin
      tier_q <= `CPUC_TIER_NONE;
      src_q <= 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memories and timers

  cpuc_mem #(.AW(5), .DW(8)) u_bank_mem ( // RULE5
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(take && instr_kind_in == `CPUC_K_REG_WR),
    .wr_addr_in({rs, instr_reg_idx_in}), // RULE7
    .wr_data_in(acc_q),
    .rd_addr_in({rs, instr_reg_idx_in}), // RULE7
    .rd_data_out(bank_rdata)
  );

  cpuc_mem #(.AW(8), .DW(8)) u_stack_mem ( // RULE18
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(xram_we),
    .wr_addr_in(sp_inc), // RULE15
    .wr_data_in(xram_wd),
    .rd_addr_in(xram_raddr),
    .rd_data_out(xram_rdata)
  );

  cpuc_timer16 u_tmr0 ( // RULE20
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(tctl_q[0]),
    .ld_lo_in(sfr_we && sfr_wa == `CPUC_SFR_T0L),
    .ld_hi_in(sfr_we && sfr_wa == `CPUC_SFR_T0H),
    .ld_data_in(sfr_wd),
    .cap_in(1'b0),
    .count_out(t0_cnt),
    .cap_out()
  );

  cpuc_timer16 u_tmr1 ( // RULE20
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(tctl_q[1]),
    .ld_lo_in(sfr_we && sfr_wa == `CPUC_SFR_T1L),
    .ld_hi_in(sfr_we && sfr_wa == `CPUC_SFR_T1H),
    .ld_data_in(sfr_wd),
    .cap_in(1'b0),
    .count_out(t1_cnt),
    .cap_out()
  );

  cpuc_timer16 u_tmr2 ( // RULE20
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(tctl_q[2]),
    .ld_lo_in(sfr_we && sfr_wa == `CPUC_SFR_T2L),
    .ld_hi_in(sfr_we && sfr_wa == `CPUC_SFR_T2H),
    .ld_data_in(sfr_wd),
    .cap_in(tctl_q[`CPUC_TCTL_CAPEN] & cap_s2_q & ~cap_s3_q),
    .count_out(t2_cnt),
    .cap_out(t2_cap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign fetch_address_out = pc_q;
  assign current_opcode_out = opc_q;
  assign acc_out = acc_q;
  assign mem_pointer_pair_out = cur_dp;
  assign stack_top_pointer_out = sp_q;
  assign sfr_rdata_out = rdata_q;
  assign sfr_rvalid_out = rvalid_q;
  assign irq_tier_out = tier_q;
  assign irq_src_out = src_q;
  assign idle_mode_out = xpwr_q[0];
  assign power_down_out = xpwr_q[1];

endmodule // cpuc_core_regs

// *** hdl/cpuc_defs.vh ***
// constants for the core register set: special-register addresses,
// field positions, reset values and instruction-kind codes.
// assumes inclusion by bare name from each design file that needs it.
`ifndef CPUC_DEFS_VH
`define CPUC_DEFS_VH

// special-register addresses
`define CPUC_SFR_PT0 8'h80
`define CPUC_SFR_SP 8'h81
`define CPUC_SFR_MPL 8'h82
`define CPUC_SFR_MPH 8'h83
`define CPUC_SFR_PCTL 8'h87
`define CPUC_SFR_T0L 8'h8A
`define CPUC_SFR_T1L 8'h8B
`define CPUC_SFR_T0H 8'h8C
`define CPUC_SFR_T1H 8'h8D
`define CPUC_SFR_PT1 8'h90
`define CPUC_SFR_PT2 8'hA0
`define CPUC_SFR_DPSEL 8'hA7
`define CPUC_SFR_CFG 8'hAF
`define CPUC_SFR_PU1 8'hB1
`define CPUC_SFR_PU2 8'hB2
`define CPUC_SFR_IPRIO 8'hB8
`define CPUC_SFR_XPWR 8'hC5
`define CPUC_SFR_TCTL 8'hC9
`define CPUC_SFR_CAPL 8'hCA
`define CPUC_SFR_CAPH 8'hCB
`define CPUC_SFR_T2L 8'hCC
`define CPUC_SFR_T2H 8'hCD
`define CPUC_SFR_FLG 8'hD0
`define CPUC_SFR_ACC 8'hE0
`define CPUC_SFR_B 8'hF0

// field positions
`define CPUC_FLG_CY 7
`define CPUC_FLG_AC 6
`define CPUC_FLG_RS_HI 4
`define CPUC_FLG_RS_LO 3
`define CPUC_FLG_OV 2
`define CPUC_BITADDR_MASK 8'h07
`define CPUC_TCTL_CAPEN 3

// reset values
`define CPUC_RST_PC 16'h0000
`define CPUC_RST_SP 8'h07
`define CPUC_RST_BYTE 8'h00
`define CPUC_RST_PORT 20'hFFFFF
`define CPUC_RST_CFG 8'h80
`define CPUC_RST_PU1 8'hFF
`define CPUC_RST_PU2 4'hF

// instruction kinds
`define CPUC_K_NEXT 4'h0
`define CPUC_K_JUMP 4'h1
`define CPUC_K_CALL 4'h2
`define CPUC_K_RET 4'h3
`define CPUC_K_IRQ 4'h4
`define CPUC_K_PUSH 4'h5
`define CPUC_K_POP 4'h6
`define CPUC_K_ACC_REG 4'h7
`define CPUC_K_ACC_LIT 4'h8
`define CPUC_K_MUL 4'h9
`define CPUC_K_DIV 4'hA
`define CPUC_K_SFR_WR 4'hB
`define CPUC_K_SFR_BIT 4'hC
`define CPUC_K_SFR_RD 4'hD
`define CPUC_K_REG_WR 4'hE
`define CPUC_K_MPTR_LD 4'hF

// alu operations
`define CPUC_OP_ADD 2'h0
`define CPUC_OP_ADDC 2'h1
`define CPUC_OP_SUBB 2'h2
`define CPUC_OP_MOV 2'h3

// interrupt tiers and the supply-monitor source number
`define CPUC_TIER_NONE 2'h0
`define CPUC_TIER_LOW 2'h1
`define CPUC_TIER_HIGH 2'h2
`define CPUC_TIER_SUPPLY 2'h3
`define CPUC_SRC_SUPPLY 3'h4

`endif

// *** hdl/cpuc_mem.v ***
// small synchronous memory with registered read data.
// assumes one write and one read port on the same clock; read of a word
// written in the same cycle returns the old contents.
`timescale 1ns/1ns
`include "cpuc_defs.vh"

module cpuc_mem #(
  parameter AW = 8,
  parameter DW = 8
) (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // write port
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [DW-1:0] wr_data_in,
  // read port
  input wire [AW-1:0] rd_addr_in,
  output wire [DW-1:0] rd_data_out
);

  reg [DW-1:0] mem [0:(1<<AW)-1];
  reg [DW-1:0] rd_q;

  // array carries no reset so it maps to plain ram
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_q <= {DW{1'b0}};
    end else begin
      rd_q <= mem[rd_addr_in];
    end
  end

  assign rd_data_out = rd_q;

endmodule // cpuc_mem

// *** hdl/cpuc_timer16.v ***
// one 16-bit timer/counter with byte loads and an optional capture.
// assumes the capture strobe is a one-cycle pulse on clk_in.
`timescale 1ns/1ns
`include "cpuc_defs.vh"

module cpuc_timer16 (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // control
  input wire run_in,
  input wire ld_lo_in,
  input wire ld_hi_in,
  input wire [7:0] ld_data_in,
  input wire cap_in,
  // state
  output wire [15:0] count_out,
  output wire [15:0] cap_out
);

  reg [15:0] count_q;
  reg [15:0] cap_q;

  // a byte load wins over counting in the same cycle
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_q <= {`CPUC_RST_BYTE, `CPUC_RST_BYTE};
      cap_q <= {`CPUC_RST_BYTE, `CPUC_RST_BYTE};
    end else begin
      if (ld_lo_in) begin
        count_q[7:0] <= ld_data_in;
      end else if (ld_hi_in) begin
        count_q[15:8] <= ld_data_in;
      end else if (run_in) begin
        count_q <= count_q + 16'h0001;
      end
      if (cap_in) begin
        cap_q <= count_q;
      end
    end
  end

  assign count_out = count_q;
  assign cap_out = cap_q;

endmodule // cpuc_timer16

// *** tb/cpu_core_registers_test.sv ***
// self-checking bench for the core register set
// assumes cpuc_core_regs with default irq count; pins idle high
`timescale 1ns/1ns
module cpu_core_registers_test;
  reg clk_in = 1'b0;
  reg resetn_in = 1'b0;
  reg v = 1'b0;
  reg [3:0] k = 4'h0;
  reg [7:0] opc = 8'h00;
  reg [1:0] len = 2'h1;
  reg [1:0] aop = 2'h3;
  reg [2:0] idx = 3'h0;
  reg [7:0] opd = 8'h00;
  reg [15:0] tgt = 16'h0000;
  reg [15:0] e;
  reg [7:0] r;
  wire rdy;
  wire [15:0] pc;
  wire [7:0] op, acc, sp, rd;
  integer mismatches = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer i;
  cpuc_core_regs u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .instr_valid_in(v),
    .instr_kind_in(k), .instr_opcode_in(opc), .instr_len_in(len), .instr_alu_op_in(aop),
    .instr_reg_idx_in(idx), .instr_operand_in(opd), .instr_target_in(tgt),
    .instr_ready_out(rdy), .fetch_address_out(pc), .current_opcode_out(op), .acc_out(acc),
    .mem_pointer_pair_out(), .stack_top_pointer_out(sp), .sfr_rdata_out(rd),
    .sfr_rvalid_out(), .pin_in(20'hFFFFF), .pin_out(), .pin_oe_out(), .pullup_en_out(),
    .capture_pin_in(1'b0), .irq_req_in(4'h0), .supply_monitor_irq_in(1'b0),
    .irq_tier_out(), .irq_src_out(), .idle_mode_out(), .power_down_out());
  initial forever #25 clk_in = ~clk_in;
  ////////////////////
  task wrap_up;
    begin
      if (mismatches == 0 && checks_done > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [47:0] nm, input [15:0] ex, input [15:0] got);
    begin
      checks_done = checks_done + 1;
      if (ex !== got) begin
        mismatches = mismatches + 1;
        $display("BAD %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  // offer at a falling edge, hold until taken, release one cycle later
  task issue(input [3:0] ki, input [7:0] od, input [15:0] tg, input [1:0] ln);
    begin
      @(negedge clk_in);
      k = ki;
      opd = od;
      tgt = tg;
      len = ln;
      opc = $urandom;
      idx = $urandom;
      v = 1'b1;
      #1;
      while (rdy !== 1'b1) @(negedge clk_in);
      @(negedge clk_in);
      v = 1'b0;
      chk("opcode", {8'h00, opc}, {8'h00, op});
    end
  endtask
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  ////////////////////
  initial begin
    i = $urandom(32'h930546BE);
    repeat (16) @(negedge clk_in);
    resetn_in = 1'b1;
    chk("pc", 16'h0000, pc);
    for (i = 0; i < 40; i = i + 1) begin
      aop = $urandom;
      len = $urandom_range(3, 1);
      e = pc + len;
      issue(4'h0, 8'h00, 16'h0000, len);
      chk("pc", e, pc);
    end
    e = $urandom;
    issue(4'h1, 8'h00, e, 2'h3);
    chk("jump", e, pc);
    aop = 2'h3;
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      if (i < 2)
        r = {8{i[0]}};
      issue(4'h8, r, 16'h0000, 2'h2);
      @(negedge clk_in);
      chk("acc", {8'h00, r}, {8'h00, acc});
      issue(4'hD, 8'hD0, 16'h0000, 2'h2);
      chk("parity", {15'h0000, ^r}, {15'h0000, rd[0]});
    end
    issue(4'hB, 8'h81, 16'h00FF, 2'h3);
    chk("sp", 16'h00FF, {8'h00, sp});
    issue(4'h5, 8'hE0, 16'h0000, 2'h2);
    chk("sp", 16'h0000, {8'h00, sp});
    issue(4'h6, 8'hF0, 16'h0000, 2'h2);
    @(negedge clk_in);
    chk("sp", 16'h00FF, {8'h00, sp});
    issue(4'hD, 8'hF0, 16'h0000, 2'h2);
    chk("aux", {8'h00, r}, {8'h00, rd});
    e = pc + 16'h0003;
    issue(4'h2, 8'h00, {r, ~r}, 2'h3);
    chk("call", {r, ~r}, pc);
    @(negedge clk_in);
    chk("sp", 16'h0001, {8'h00, sp});
    issue(4'h3, 8'h00, 16'h0000, 2'h1);
    repeat (2) @(negedge clk_in);
    chk("ret", e, pc);
    chk("sp", 16'h00FF, {8'h00, sp});
    wrap_up;
  end
endmodule // cpu_core_registers_test

// *** tb/cpuc_core_regs_assertions.sv ***
// port checker for the core register set
// assumes binding onto cpuc_core_regs, one clock domain
`timescale 1ns/1ns
module cpuc_chk (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // watched ports
  input wire instr_valid_in,
  input wire instr_ready_out,
  input wire [3:0] instr_kind_in,
  input wire [7:0] instr_opcode_in,
  input wire [7:0] instr_operand_in,
  input wire [1:0] instr_len_in,
  input wire [15:0] instr_target_in,
  input wire [15:0] fetch_address_out,
  input wire [7:0] current_opcode_out,
  input wire [7:0] stack_top_pointer_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire tk = instr_valid_in && instr_ready_out;
  wire [3:0] k = instr_kind_in;
  wire [7:0] sp = stack_top_pointer_out;
  wire [15:0] pc = fetch_address_out;
  ////////////////////
  property p_rst; $rose(resetn_in) |-> pc == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("pc not zero");
  property p_len; tk && k == 4'h0 |=> pc == $past(pc) + $past(instr_len_in); endproperty
  a_len: assert property (p_len) else $error("pc step");
  property p_jmp; tk && k == 4'h1 |=> pc == $past(instr_target_in); endproperty
  a_jmp: assert property (p_jmp) else $error("jump target");
  property p_opc; tk |=> current_opcode_out == $past(instr_opcode_in); endproperty
  a_opc: assert property (p_opc) else $error("opcode hold");
  property p_psh; tk && k == 4'h5 |=> sp == $past(sp) + 8'h01; endproperty
  a_psh: assert property (p_psh) else $error("push sp");
  // a pop into the pointer itself lets the write win
  property p_pop; tk && k == 4'h6 && instr_operand_in != 8'h81
    |=> ##1 sp == $past(sp, 2) - 8'h01; endproperty
  a_pop: assert property (p_pop) else $error("pop sp");
  property p_cal; tk && k == 4'h2
    |=> pc == $past(instr_target_in) ##1 sp == $past(sp, 2) + 8'h02; endproperty
  a_cal: assert property (p_cal) else $error("call");
  property p_lit; tk && k == 4'h8 |=> !instr_ready_out; endproperty
  a_lit: assert property (p_lit) else $error("literal op");
  c_psh: cover property (tk && k == 4'h5);
  c_pop: cover property (tk && k == 4'h6);
  c_cal: cover property (tk && k == 4'h2);
endmodule // cpuc_chk

bind cpuc_core_regs cpuc_chk u_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out),
  .instr_kind_in(instr_kind_in), .instr_opcode_in(instr_opcode_in),
  .instr_operand_in(instr_operand_in), .instr_len_in(instr_len_in),
  .instr_target_in(instr_target_in), .fetch_address_out(fetch_address_out),
  .current_opcode_out(current_opcode_out), .stack_top_pointer_out(stack_top_pointer_out));
